// ==== verilog/psc_pkg.sv ====
// shared constants, register map and state type of the serial configuration loader
package psc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int TIMER_W = 16;
  // error hold before automatic release, a longest time so it rounds down
  localparam int ERR_RELEASE_US = 80;
  localparam int ERR_RELEASE_CYC = ERR_RELEASE_US * CLK_PER_US;
  // internal start-up time when no user start-up clock is used
  localparam int INIT_INTERNAL_US = 300;
  localparam int INIT_INTERNAL_CYC = INIT_INTERNAL_US * CLK_PER_US;
  // user start-up clock: enable delay edges, then edges needed to reach user mode
  localparam int USER_ENABLE_EDGES = 4;
  localparam int USER_INIT_EDGES = 3180;
  localparam int INIT_USER_TOTAL = USER_ENABLE_EDGES + USER_INIT_EDGES;
  // register bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BITLEN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BITCOUNT = 8'h0c;
  localparam logic [7:0] REG_LASTBYTE = 8'h10;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_USERCLK_BIT = 1;
  localparam int CTRL_FORCE_BIT = 2;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] BITLEN_RESET = 32'h0000_0100;
  localparam int STATUS_ERR_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // bit counts at which the two sync bytes complete
  localparam logic [31:0] SYNC_BYTE0_BITS = 32'h0000_0008;
  localparam logic [31:0] SYNC_BYTE1_BITS = 32'h0000_0010;
  localparam int STATE_W = 3;
  typedef enum logic [STATE_W-1:0] {
    ST_RESET,
    ST_RELEASE,
    ST_LOAD,
    ST_ERROR,
    ST_DONE,
    ST_INIT,
    ST_USER
  } psc_state_t;
endpackage

// ==== verilog/psc_shift_if.sv ====
// link between the loader control and the serial bit collector
`timescale 1ns/1ps
interface psc_shift_if;
  logic sample;
  logic bit_in;
  logic clear;
  logic [7:0] byte_val;
  logic byte_ready;
  logic [31:0] bits;
  modport ctl (output sample, output bit_in, output clear,
               input byte_val, input byte_ready, input bits);
  modport shf (input sample, input bit_in, input clear,
               output byte_val, output byte_ready, output bits);
endinterface

// ==== verilog/psc_shifter.sv ====
// serial bit collector: counts bits and assembles bytes least significant bit first
`timescale 1ns/1ps
module psc_shifter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // collector port
  psc_shift_if.shf sh
);
  logic [7:0] sr, next_sr;
  logic [7:0] byte_val, next_byte;
  logic byte_ready, next_ready;
  logic [31:0] bits, next_bits;

  always_comb begin
    next_sr = sr;
    next_bits = bits;
    next_byte = byte_val;
    next_ready = 1'b0;
    if (sh.clear) begin
      next_sr = '0;
      next_bits = '0;
    end else if (sh.sample) begin
      // first bit lands at the bottom once all eight have shifted in
      next_sr = {sh.bit_in, sr[7:1]};
      next_bits = bits + 32'h1;
      if (bits[2:0] == 3'h7) begin
        next_byte = {sh.bit_in, sr[7:1]};
        next_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr <= '0;
      bits <= '0;
      byte_val <= '0;
      byte_ready <= 1'b0;
    end else begin
      sr <= next_sr;
      bits <= next_bits;
      byte_val <= next_byte;
      byte_ready <= next_ready;
    end
  end

  assign sh.byte_val = byte_val;
  assign sh.byte_ready = byte_ready;
  assign sh.bits = bits;

  AST_SAMPLE_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    sh.sample && !sh.clear |=> bits == $past(bits) + 32'h1)
    else $error("bit count did not advance on a sample");
  AST_LSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    sh.sample && !sh.clear && bits[2:0] == 3'h7 |=> byte_ready && byte_val[7] == $past(sh.bit_in))
    else $error("byte not assembled least significant bit first");
endmodule

// ==== verilog/psc_chain_top.sv ====
// passive serial configuration loader of one device in a configuration chain
//
// Functional notes
// - data pin stays tri-stated in user mode
// - no maximum serial clock period
// - error drives status low, resets internally
// - auto restart releases status within 80 us
// - request low: status, done low, I/O off
// - load only after request high, status released
// - chain enable out low once configured
// - accept data one serial clock after enable
// - shared done line starts initialization together
// - any status low halts the whole chain; user mode ignores it
// - data sampled on serial clock rising edge
// - user clock: 3180 cycles after enable delay
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module psc_chain_top import psc_pkg::*; #(
  parameter logic [15:0] SYNC_WORD = 16'h5aa5,
  parameter int INIT_CYCLES = INIT_INTERNAL_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration pins from the host
  input wire logic config_serial_clock,
  input wire logic config_request_n,
  input wire logic user_startup_clock,
  input wire logic chain_enable_in_n,
  // serial data pin, two-way
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  // open-drain status line
  input wire logic status_error_n_in,
  output logic status_error_n_out,
  output logic status_error_n_oe_n,
  // open-drain done line
  input wire logic config_done_flag_in,
  output logic config_done_flag_out,
  output logic config_done_flag_oe_n,
  // chain and device state
  output logic chain_enable_out_n,
  output logic init_complete_flag,
  output logic user_io_hiz
);
  if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << TIMER_W) || INIT_USER_TOTAL >= (1 << TIMER_W)
      || ERR_RELEASE_CYC >= (1 << TIMER_W)) begin : g_bad_count
    $error("start-up or error counts do not fit the timer");
  end

  localparam int NSYNC = 7;
  localparam logic [TIMER_W-1:0] ERR_LAST = TIMER_W'(ERR_RELEASE_CYC - 1);
  localparam logic [TIMER_W-1:0] INIT_LAST = TIMER_W'(INIT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] USER_LAST = TIMER_W'(INIT_USER_TOTAL - 1);

  function automatic logic holds_status(psc_state_t s);
    return (s == ST_RESET) || (s == ST_ERROR);
  endfunction

  function automatic logic is_done(psc_state_t s);
    return (s == ST_DONE) || (s == ST_INIT) || (s == ST_USER);
  endfunction

  function automatic logic reg_known(logic [AXI_ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_BITLEN) || (a == REG_STATUS)
        || (a == REG_BITCOUNT) || (a == REG_LASTBYTE);
  endfunction

  function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // every pin passes two flops; the serial clock is only a sampled level here
  logic [NSYNC-1:0] pin_raw, sync_a, sync_b;
  logic config_serial_clock_d, uclk_d;
  assign pin_raw = {user_startup_clock, chain_enable_in_n, config_done_flag_in,
                    status_error_n_in, config_request_n, serial_data_in, config_serial_clock};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
      config_serial_clock_d <= 1'b0;
      uclk_d <= 1'b0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      config_serial_clock_d <= sync_b[0];
      uclk_d <= sync_b[6];
    end
  end

  logic config_serial_clock_s, data_s, req_s, stat_s, done_s, cein_s, uclk_s;
  logic config_serial_clock_rise, uclk_rise;
  assign config_serial_clock_s = sync_b[0];
  assign data_s = sync_b[1];
  assign req_s = sync_b[2];
  assign stat_s = sync_b[3];
  assign done_s = sync_b[4];
  assign cein_s = sync_b[5];
  assign uclk_s = sync_b[6];
  // serial clock is 160 ns in the bench; anything under one aclk period per half can be lost
  assign config_serial_clock_rise = config_serial_clock_s & ~config_serial_clock_d;
  assign uclk_rise = uclk_s & ~uclk_d;

  // register file state
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] bitlen, next_bitlen;
  logic err_seen, next_err_seen;
  logic force_err, next_force_err;

  // loader state
  psc_state_t state, next_state;
  logic [TIMER_W-1:0] timer, next_timer;
  logic err_event;
  logic sync_bad;
  psc_shift_if sh ();

  psc_shifter u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sh(sh)
  );

  assign sync_bad = sh.byte_ready
      && ((sh.bits == SYNC_BYTE0_BITS && sh.byte_val != SYNC_WORD[7:0])
       || (sh.bits == SYNC_BYTE1_BITS && sh.byte_val != SYNC_WORD[15:8]));

  always_comb begin
    next_state = state;
    next_timer = timer;
    err_event = 1'b0;
    sh.sample = 1'b0;
    sh.bit_in = data_s;
    sh.clear = 1'b0;
    case (state)
      ST_RESET: begin
        next_timer = '0;
        sh.clear = 1'b1;
        if (req_s) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        sh.clear = 1'b1;
        if (stat_s) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // no watchdog on the serial clock: a stopped clock simply holds the count
        sh.sample = config_serial_clock_rise & ~cein_s;
        if (!stat_s) begin
          next_state = ST_RELEASE;
        end else if (force_err || sync_bad) begin
          next_state = ST_ERROR;
          err_event = 1'b1;
          next_timer = '0;
        end else if (bitlen != '0 && sh.bits == bitlen) begin
          next_state = ST_DONE;
        end
      end
      ST_ERROR: begin
        next_timer = timer + TIMER_W'(1);
        if (ctrl[CTRL_AUTO_BIT] && timer == ERR_LAST) begin
          next_state = ST_RELEASE;
        end
      end
      ST_DONE: begin
        if (!stat_s) begin
          next_state = ST_RELEASE;
        end else if (done_s) begin
          next_state = ST_INIT;
          next_timer = '0;
        end
      end
      ST_INIT: begin
        if (!stat_s) begin
          next_state = ST_RELEASE;
        end else if (ctrl[CTRL_USERCLK_BIT]) begin
          if (uclk_rise) begin
            if (timer == USER_LAST) begin
              next_state = ST_USER;
            end else begin
              next_timer = timer + TIMER_W'(1);
            end
          end
        end else if (timer == INIT_LAST) begin
          next_state = ST_USER;
        end else begin
          next_timer = timer + TIMER_W'(1);
        end
      end
      ST_USER: begin
        next_timer = timer;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    if (!req_s) begin
      next_state = ST_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RESET;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // pins follow the next state so they line up with the state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_error_n_oe_n <= 1'b0;
      status_error_n_out <= 1'b0;
      config_done_flag_oe_n <= 1'b0;
      config_done_flag_out <= 1'b0;
      chain_enable_out_n <= 1'b1;
      init_complete_flag <= 1'b0;
      user_io_hiz <= 1'b1;
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end else begin
      status_error_n_oe_n <= ~holds_status(next_state);
      status_error_n_out <= 1'b0;
      config_done_flag_oe_n <= is_done(next_state);
      config_done_flag_out <= 1'b0;
      chain_enable_out_n <= ~is_done(next_state);
      init_complete_flag <= (next_state == ST_USER);
      user_io_hiz <= (next_state != ST_USER);
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end
  end

  // axi4-lite slave
  logic aw_have, next_aw_have, w_have, next_w_have;
  logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic err_clear;

  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_ctrl = ctrl;
    next_bitlen = bitlen;
    next_force_err = 1'b0;
    err_clear = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr == REG_CTRL) begin
        next_ctrl = apply_strb(ctrl, w_data, w_strb) & CTRL_WMASK;
        next_force_err = w_strb[0] & w_data[CTRL_FORCE_BIT];
      end
      if (aw_addr == REG_BITLEN) begin
        next_bitlen = apply_strb(bitlen, w_data, w_strb);
      end
      if (aw_addr == REG_STATUS) begin
        err_clear = w_strb[1] & w_data[STATUS_ERR_BIT];
      end
    end
    // a new error in the clearing cycle stays visible
    next_err_seen = (err_seen & ~err_clear) | err_event;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL: next_rdata = ctrl;
        REG_BITLEN: next_rdata = bitlen;
        REG_STATUS: next_rdata = 32'(state) | (32'(err_seen) << STATUS_ERR_BIT);
        REG_BITCOUNT: next_rdata = sh.bits;
        REG_LASTBYTE: next_rdata = 32'(sh.byte_val);
        default: next_rdata = '0;
      endcase
    end
    next_awready = ~next_aw_have & ~next_bvalid;
    next_wready = ~next_w_have & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      ctrl <= CTRL_RESET;
      bitlen <= BITLEN_RESET;
      err_seen <= 1'b0;
      force_err <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      ctrl <= next_ctrl;
      bitlen <= next_bitlen;
      err_seen <= next_err_seen;
      force_err <= next_force_err;
    end
  end

  // cycles spent in the error state, kept apart from the release timer it checks
  logic [TIMER_W-1:0] err_hold, next_err_hold;

  always_comb begin
    next_err_hold = '0;
    if (state == ST_ERROR) begin
      next_err_hold = (err_hold == '1) ? err_hold : err_hold + TIMER_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_hold <= '0;
    end else begin
      err_hold <= next_err_hold;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_REQ_LOW_RESETS: assert property (
    !req_s |=> !status_error_n_oe_n && !config_done_flag_oe_n && user_io_hiz)
    else $error("request low did not pull status and done low");
  AST_ERR_DRIVES: assert property (
    state == ST_ERROR |-> !status_error_n_oe_n && chain_enable_out_n)
    else $error("error state not driving status low");
  AST_ERR_RELEASE: assert property (
    state == ST_ERROR && ctrl[CTRL_AUTO_BIT] |-> err_hold <= ERR_LAST)
    else $error("status not released within the error hold time");
  AST_LOAD_ENTRY: assert property (
    $rose(state == ST_LOAD) |-> $past(req_s) && $past(stat_s))
    else $error("load began before request high and status released");
  AST_CHAIN_OUT: assert property (
    !chain_enable_out_n |-> is_done(state) && !config_done_flag_oe_n == 1'b0)
    else $error("chain enable out low before configuration done");
  AST_HANDOVER: assert property (
    state == ST_LOAD && next_state == ST_LOAD && !cein_s && config_serial_clock_rise
      |=> sh.bits == $past(sh.bits) + 32'h1)
    else $error("enabled device did not take the serial bit");
  AST_INIT_SHARED: assert property (
    $rose(state == ST_INIT) |-> $past(done_s) && $past(state) == ST_DONE)
    else $error("initialization started without the shared done line");
  AST_CHAIN_HALT: assert property (
    req_s && !stat_s && (state == ST_LOAD || state == ST_DONE || state == ST_INIT)
      |=> state == ST_RELEASE)
    else $error("status low from the chain did not halt loading");
  AST_USER_CLOCK: assert property (
    $rose(state == ST_USER) && ctrl[CTRL_USERCLK_BIT] |-> $past(timer) == USER_LAST)
    else $error("user mode reached with wrong start-up clock count");
  AST_DATA_HIZ: assert property (
    init_complete_flag |-> serial_data_oe_n)
    else $error("data pin driven in user mode");
endmodule

// ==== test/psc_host_model.sv ====
// host model: drives serial clock, data and request of the loader
`timescale 1ns/1ps
module psc_host_model (
  // system clock
  input wire logic aclk,
  // host pins
  output logic sclk,
  output logic sdata,
  output logic request_n,
  // resolved status line
  input wire logic status_n
);
  logic stopped;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    request_n = 1'b0;
    stopped = 1'b0;
  end
  task automatic pulse_request(input int cyc);
    @(posedge aclk);
    request_n <= 1'b0;
    repeat (cyc) @(posedge aclk);
    request_n <= 1'b1;
  endtask
  // 160 ns clock, standing low between bytes; data moves only while the clock is low
  task automatic send_byte(input logic [7:0] b);
    stopped = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (status_n !== 1'b1) stopped = 1'b1;
      if (!stopped) begin
        sdata <= b[i];
        repeat (4) @(posedge aclk);
        sclk <= 1'b1;
        repeat (4) @(posedge aclk);
        sclk <= 1'b0;
      end
    end
  endtask
  task automatic send_stream(input logic [7:0] d [$]);
    foreach (d[i]) send_byte(d[i]);
    // still driven, but never the stale bit
    sdata <= ~sdata;
  endtask
endmodule

// ==== test/passive_serial_config_chain_tb.sv ====
// self-checking bench of the serial configuration loader
`timescale 1ns/1ps
module passive_serial_config_chain_tb import psc_pkg::*; ;
  localparam logic [15:0] SYNC = 16'h5aa5;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sclk, sdata, req_n, uclk, chain_in_n;
  logic d_out, d_oe_n, st_out, st_oe_n, dn_out, dn_oe_n, chain_out_n, init_flag, io_hiz;
  logic other_n, status_n, done_n, data_pin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  int errors, n_checks, wn;
  // pulled-up open-drain lines; a second device may pull status low
  assign status_n = (st_oe_n ? 1'b1 : st_out) & other_n;
  assign done_n = dn_oe_n ? 1'b1 : dn_out;
  assign data_pin = d_oe_n ? sdata : d_out;
  psc_chain_top #(.SYNC_WORD(SYNC), .INIT_CYCLES(20)) i_psc_chain_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .config_serial_clock(sclk), .config_request_n(req_n), .user_startup_clock(uclk),
    .chain_enable_in_n(chain_in_n), .serial_data_in(data_pin), .serial_data_out(d_out),
    .serial_data_oe_n(d_oe_n), .status_error_n_in(status_n), .status_error_n_out(st_out),
    .status_error_n_oe_n(st_oe_n), .config_done_flag_in(done_n),
    .config_done_flag_out(dn_out), .config_done_flag_oe_n(dn_oe_n),
    .chain_enable_out_n(chain_out_n), .init_complete_flag(init_flag), .user_io_hiz(io_hiz));
  psc_host_model i_psc_host_model (
    .aclk(aclk), .sclk(sclk), .sdata(sdata), .request_n(req_n), .status_n(status_n));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic guard(input int lim);
    @(posedge aclk);
    wn++;
    if (wn > lim) begin
      errors++;
      $display("wrong value at %0t: wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    // one edge between transfers so bready is never set twice in a step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wn = 0;
    do begin
      guard(100);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "bresp");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wn = 0;
    do begin
      guard(100);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    chk(rresp, er, "rresp");
  endtask
  task automatic load(input logic [7:0] last);
    i_psc_host_model.pulse_request(25);
    wn = 0;
    while (st_oe_n !== 1'b1) guard(50);
    i_psc_host_model.send_stream({SYNC[7:0], SYNC[15:8], 8'h3c});
    // long pause with the serial clock stopped
    repeat (2000) @(posedge aclk);
    i_psc_host_model.send_stream({last});
    wn = 0;
    while (dn_oe_n !== 1'b1) guard(10);
  endtask
  task automatic s_reset();
    chk({st_oe_n, dn_oe_n, io_hiz, chain_out_n}, 4'h3, "in reset");
    axi_rd(REG_CTRL, RESP_OKAY);
    chk(rd, CTRL_RESET, "ctrl");
    axi_rd(REG_BITLEN, RESP_OKAY);
    chk(rd, BITLEN_RESET, "bitlen");
    axi_rd(8'h20, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped");
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    axi_wr(REG_BITLEN, 32'h20, RESP_OKAY);
  endtask
  task automatic s_load();
    load(8'hc3);
    chk(chain_out_n, 1'b0, "chain out");
    axi_rd(REG_BITCOUNT, RESP_OKAY);
    chk(rd, 32'h20, "bit count");
    axi_rd(REG_LASTBYTE, RESP_OKAY);
    chk(rd, 32'hc3, "last byte");
    wn = 0;
    while (init_flag !== 1'b1) guard(40);
    chk({io_hiz, d_oe_n}, 2'h1, "user pins");
    chk({d_out, st_out, dn_out}, 3'h0, "driven levels");
  endtask
  task automatic s_reconfig();
    fork
      i_psc_host_model.pulse_request(25000);
      begin
        repeat (8) @(posedge aclk);
        chk({st_oe_n, dn_oe_n, io_hiz, init_flag}, 4'h2, "request low");
        repeat (24000) @(posedge aclk);
        chk(st_oe_n, 1'b0, "status held");
      end
    join
    wn = 0;
    while (st_oe_n !== 1'b1) guard(50);
  endtask
  task automatic s_err_auto();
    int c;
    i_psc_host_model.send_stream({8'hff, 8'hff, 8'hff});
    chk(st_oe_n, 1'b0, "error status");
    c = 0;
    while (st_oe_n !== 1'b1 && c < 5000) begin
      @(posedge aclk);
      c++;
    end
    chk(c > ERR_RELEASE_CYC - 100 && c <= ERR_RELEASE_CYC, 1'b1, "release time");
    axi_rd(REG_STATUS, RESP_OKAY);
    chk(rd[STATUS_ERR_BIT], 1'b1, "error seen");
    axi_wr(REG_STATUS, 32'h1 << STATUS_ERR_BIT, RESP_OKAY);
    axi_rd(REG_STATUS, RESP_OKAY);
    chk(rd[STATUS_ERR_BIT], 1'b0, "error cleared");
  endtask
  task automatic s_err_hold();
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    i_psc_host_model.send_stream({8'h00, 8'h00, 8'h00});
    repeat (4200) @(posedge aclk);
    chk(st_oe_n, 1'b0, "no auto release");
    i_psc_host_model.pulse_request(25);
    wn = 0;
    while (st_oe_n !== 1'b1) guard(50);
    axi_wr(REG_CTRL, CTRL_RESET, RESP_OKAY);
  endtask
  task automatic s_chain();
    chain_in_n <= 1'b1;
    i_psc_host_model.send_stream({SYNC[7:0]});
    axi_rd(REG_BITCOUNT, RESP_OKAY);
    chk(rd, 32'h0, "chain disabled");
    chain_in_n <= 1'b0;
    repeat (4) @(posedge aclk);
    i_psc_host_model.send_stream({SYNC[7:0]});
    axi_rd(REG_BITCOUNT, RESP_OKAY);
    chk(rd, 32'h8, "chain enabled");
    other_n <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_rd(REG_STATUS, RESP_OKAY);
    chk({rd[2:0], st_oe_n}, 4'h3, "shared error");
    other_n <= 1'b1;
  endtask
  task automatic s_userclk();
    repeat (4) @(posedge aclk);
    axi_wr(REG_CTRL, 32'h3 | (32'h1 << CTRL_FORCE_BIT), RESP_OKAY);
    @(posedge aclk);
    chk(st_oe_n, 1'b0, "forced error");
    load(8'h3c);
    repeat (20) @(posedge aclk);
    for (int i = 0; i < INIT_USER_TOTAL; i++) begin
      if (i == INIT_USER_TOTAL - 1) chk(init_flag, 1'b0, "early user");
      repeat (4) @(posedge aclk);
      uclk <= 1'b1;
      repeat (4) @(posedge aclk);
      uclk <= 1'b0;
    end
    wn = 0;
    while (init_flag !== 1'b1) guard(8);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, uclk, chain_in_n} = '0;
    {awaddr, araddr, wdata} = '0;
    other_n = 1'b1;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_load();
    s_reconfig();
    s_err_auto();
    s_err_hold();
    s_chain();
    s_userclk();
    stop_test();
  end
endmodule
